// File: hdl/ctmc_map.svh
`ifndef CTMC_MAP_SVH
`define CTMC_MAP_SVH

// Register byte offsets.
`define CTMC_OFS_CTRL 12'h000
`define CTMC_OFS_COUNT 12'h004
`define CTMC_OFS_ISTAT 12'h008
`define CTMC_OFS_ICLR 12'h00c
`define CTMC_OFS_IEN 12'h010

// Control register field positions.
`define CTMC_SEL_LSB 0
`define CTMC_SEL_MSB 2
`define CTMC_MODE_LSB 3
`define CTMC_MODE_MSB 5
`define CTMC_RUN 6
`define CTMC_UD 7
`define CTMC_UDE 8
`define CTMC_OE 9
`define CTMC_OTL 10
`define CTMC_FM 11
`define CTMC_EDGE 12
`define CTMC_CHDIR 13
`define CTMC_RDIR 14
`define CTMC_IREN 15

// Mode codes.
`define CTMC_M_TIMER 3'h0
`define CTMC_M_COUNTER 3'h1
`define CTMC_M_GATE_LO 3'h2
`define CTMC_M_GATE_HI 3'h3
`define CTMC_M_INC_ROT 3'h6
`define CTMC_M_INC_EDGE 3'h7

// Input selection codes for counter and incremental modes.
`define CTMC_S_NONE 3'h0
`define CTMC_S_ONE 3'h1
`define CTMC_S_TWO 3'h2
`define CTMC_S_BOTH 3'h3

// Prescaler: divide by two to the power of base plus selection.
`define CTMC_PRE_BASE_LOG 4'h3

// Interrupt status bit positions.
`define CTMC_IS_OVF 0
`define CTMC_IS_EDGE 1
`define CTMC_IS_CHDIR 2

// Reset values and count limits.
`define CTMC_CTRL_RST 16'h0000
`define CTMC_INT_RST 3'h0
`define CTMC_CNT_MAX 16'hffff
`define CTMC_CNT_MIN 16'h0000

`endif

// File: hdl/ctmc_pkg.sv
package ctmc_pkg;

    // Sixteen bit register word.
    typedef logic [15:0] ctmc_word_t;

    // Three bit mode or selection field.
    typedef logic [2:0] ctmc_field_t;

    // Interrupt status, clear and enable layout.
    typedef logic [2:0] ctmc_int_t;

endpackage

// File: hdl/ctmc_top.sv
// What this block does
// R1 - One sixteen bit readable and writable control register, cleared to zero by reset.
// R2 - Mode field bits 5 to 3 picks timer, counter, gated or incremental.
// R3 - Selection field bits 2 to 0 means prescaler or edge depending on mode.
// R4 - Timer codes 0 to 6 divide by 8 to 512, or 4 to 256 fast.
// R5 - Timer code 7 divides by 512 fast, otherwise by 1024.
// R6 - Fast bit 11 halves every prescaler ratio.
// R7 - Run bit 6 starts the timer when set and stops it when clear.
// R8 - Without external direction, bit 7 clear counts up, set counts down.
// R9 - Outside incremental modes, bit 8 chooses software bit or external direction input as direction source.
// R10 - Bit 9 set puts the toggle latch on the output pin, else low.
// R11 - Bit 10 inverts on each overflow or underflow and software may write it.
// R12 - Bit 12 is set on each counted edge in counter and incremental edge modes, cleared by software.
// R13 - Bit 13 is set on each direction change, cleared by software.
// R14 - Read only bit 14 shows 0 counting up and 1 counting down.
// R15 - Bit 15 lets edge and direction change flags raise the interrupt.
// R16 - Counter mode codes pick no edge, rising, falling or either edge.
// R17 - Incremental codes pick stopped, count pin, direction pin or both.
// R18 - Gated modes advance only while running and the gate is active.
// R19 - Software never writes reserved mode or selection codes.
`timescale 1ns/1ps
`include "ctmc_map.svh"

module ctmc_top
#(
    parameter int ADDR_W = 12,
    parameter int PRE_W = 10
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_input_pin,
    input wire logic ext_direction_input,
    output logic toggle_output_pin,
    output logic irq
);

    // The prescaler must reach a ratio of 1024 and decode twelve offset bits.
    // The check runs at elaboration, so a bad parameter set never simulates.
    generate
        if (PRE_W < 10 || ADDR_W < 12)
        begin : g_param_check
            $error("ctmc_top: PRE_W must be at least 10 and ADDR_W at least 12.");
        end
    endgenerate

    // All state of the block.
    typedef struct packed {
        ctmc_pkg::ctmc_word_t ctrl;
        ctmc_pkg::ctmc_word_t count;
        logic [PRE_W-1:0] pre;
        logic a1;
        logic a2;
        logic a3;
        logic b1;
        logic b2;
        logic b3;
        ctmc_pkg::ctmc_int_t istat;
        ctmc_pkg::ctmc_int_t ien;
        logic [31:0] rdata;
        logic tout;
        logic irq;
    } ctmc_state_t;

    ctmc_state_t st_r;
    ctmc_state_t st_nxt;

    // Decoded bus and control values.
    logic setup_rd;
    logic acc;
    logic mapped;
    logic wr_ctrl;
    logic wr_count;
    logic wr_clr;
    logic wr_ien;
    ctmc_pkg::ctmc_field_t mode;
    ctmc_pkg::ctmc_field_t sel;
    logic run;
    logic fm;
    logic [3:0] div_log;
    logic [PRE_W-1:0] mask;
    logic tick;
    logic a_rise;
    logic a_fall;
    logic a_edge;
    logic b_edge;
    logic cnt_edge;
    logic step;
    logic edge_evt;
    logic quad;
    logic dir_down;
    logic chg;
    logic wrap;
    ctmc_pkg::ctmc_int_t ev;

    // Merges the two low byte lanes of a write into a sixteen bit word.
    function automatic ctmc_pkg::ctmc_word_t merge16(
        input ctmc_pkg::ctmc_word_t old,
        input logic [31:0] wd,
        input logic [3:0] strb
    );
        ctmc_pkg::ctmc_word_t res;
        res = old;
        if (strb[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // The slave answers every transfer with no wait state.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = st_r.rdata;
    assign toggle_output_pin = st_r.tout;
    assign irq = st_r.irq;

    // Address decode and write strobes of the access phase.
    always_comb
    begin
        setup_rd = psel & ~penable & ~pwrite;
        acc = psel & penable & pwrite;
        mapped = (paddr[11:0] == `CTMC_OFS_CTRL) || (paddr[11:0] == `CTMC_OFS_COUNT)
            || (paddr[11:0] == `CTMC_OFS_ISTAT) || (paddr[11:0] == `CTMC_OFS_ICLR)
            || (paddr[11:0] == `CTMC_OFS_IEN);
        wr_ctrl = acc && paddr[11:0] == `CTMC_OFS_CTRL;
        wr_count = acc && paddr[11:0] == `CTMC_OFS_COUNT;
        wr_clr = acc && paddr[11:0] == `CTMC_OFS_ICLR && pstrb[0];
        wr_ien = acc && paddr[11:0] == `CTMC_OFS_IEN && pstrb[0];
    end

    // Field decode and prescaler tick.
    always_comb
    begin
        mode = st_r.ctrl[`CTMC_MODE_MSB:`CTMC_MODE_LSB]; // R2
        sel = st_r.ctrl[`CTMC_SEL_MSB:`CTMC_SEL_LSB]; // R3
        run = st_r.ctrl[`CTMC_RUN]; // R7
        fm = st_r.ctrl[`CTMC_FM];
        // Ratio is two to the power of three plus code, less one when fast.
        div_log = `CTMC_PRE_BASE_LOG + {1'b0, sel} - {3'h0, fm}; // R4 R5 R6
        mask = ~({PRE_W{1'b1}} << div_log); // R4 R5
        tick = (st_r.pre & mask) == mask; // R4 R5 R6
    end

    // Edge detection on the synchronised pins.
    always_comb
    begin
        a_rise = st_r.a2 & ~st_r.a3;
        a_fall = ~st_r.a2 & st_r.a3;
        a_edge = a_rise | a_fall;
        b_edge = st_r.b2 ^ st_r.b3;
    end

    // Count event source per mode.
    always_comb
    begin
        cnt_edge = 1'b0;
        step = 1'b0;
        edge_evt = 1'b0;
        quad = 1'b0;
        unique case (mode)
            `CTMC_M_TIMER:
            begin
                step = run & tick; // R7
            end
            `CTMC_M_GATE_LO:
            begin
                step = run & tick & ~st_r.a2; // R18
            end
            `CTMC_M_GATE_HI:
            begin
                step = run & tick & st_r.a2; // R18
            end
            `CTMC_M_COUNTER:
            begin
                unique case (sel)
                    `CTMC_S_ONE:
                    begin
                        cnt_edge = a_rise; // R16
                    end
                    `CTMC_S_TWO:
                    begin
                        cnt_edge = a_fall; // R16
                    end
                    `CTMC_S_BOTH:
                    begin
                        cnt_edge = a_edge; // R16
                    end
                    default:
                    begin
                        cnt_edge = 1'b0; // R16 R19
                    end
                endcase
                step = run & cnt_edge;
                edge_evt = step; // R12
            end
            `CTMC_M_INC_ROT, `CTMC_M_INC_EDGE:
            begin
                unique case (sel)
                    `CTMC_S_ONE:
                    begin
                        cnt_edge = a_edge; // R17
                    end
                    `CTMC_S_TWO:
                    begin
                        cnt_edge = b_edge; // R17
                    end
                    `CTMC_S_BOTH:
                    begin
                        cnt_edge = a_edge | b_edge; // R17
                    end
                    default:
                    begin
                        cnt_edge = 1'b0; // R17 R19
                    end
                endcase
                quad = 1'b1;
                step = run & cnt_edge;
                // Only edge detection mode reports each counted edge.
                edge_evt = step && mode == `CTMC_M_INC_EDGE; // R12
            end
            default:
            begin
                step = 1'b0; // R19
            end
        endcase
    end

    // Counting direction and its change.
    always_comb
    begin
        if (quad)
        begin
            // Quadrature phase relation, inverted by the software bit.
            if (step && a_edge)
            begin
                dir_down = (st_r.a2 == st_r.b2) ^ st_r.ctrl[`CTMC_UD];
            end
            else if (step)
            begin
                dir_down = (st_r.a2 != st_r.b2) ^ st_r.ctrl[`CTMC_UD];
            end
            else
            begin
                dir_down = st_r.ctrl[`CTMC_RDIR];
            end
        end
        else if (st_r.ctrl[`CTMC_UDE])
        begin
            dir_down = st_r.b2; // R9
        end
        else
        begin
            dir_down = st_r.ctrl[`CTMC_UD]; // R8 R9
        end
        chg = dir_down != st_r.ctrl[`CTMC_RDIR]; // R13
        if (dir_down)
        begin
            wrap = st_r.count == `CTMC_CNT_MIN;
        end
        else
        begin
            wrap = st_r.count == `CTMC_CNT_MAX;
        end
    end

    // Next state of the whole block.
    always_comb
    begin
        st_nxt = st_r;
        // Two flip-flop synchronisers and an edge history stage.
        st_nxt.a1 = count_input_pin;
        st_nxt.a2 = st_r.a1;
        st_nxt.a3 = st_r.a2;
        st_nxt.b1 = ext_direction_input;
        st_nxt.b2 = st_r.b1;
        st_nxt.b3 = st_r.b2;
        st_nxt.pre = st_r.pre + 1'b1; // R4
        // Software write to control keeps the read only direction bit.
        if (wr_ctrl)
        begin
            st_nxt.ctrl = merge16(st_r.ctrl, pwdata, pstrb); // R1 R11
            st_nxt.ctrl[`CTMC_RDIR] = st_r.ctrl[`CTMC_RDIR]; // R14
        end
        st_nxt.ctrl[`CTMC_RDIR] = dir_down; // R14
        // A count write takes priority over a step in the same cycle.
        if (wr_count)
        begin
            st_nxt.count = merge16(st_r.count, pwdata, pstrb);
        end
        else if (step)
        begin
            if (dir_down)
            begin
                st_nxt.count = st_r.count - 1'b1; // R8
            end
            else
            begin
                st_nxt.count = st_r.count + 1'b1; // R8
            end
        end
        // Hardware sets apply after the write, so a set is never lost.
        if (step & wrap & ~wr_count)
        begin
            st_nxt.ctrl[`CTMC_OTL] = ~st_nxt.ctrl[`CTMC_OTL]; // R11
        end
        if (edge_evt)
        begin
            st_nxt.ctrl[`CTMC_EDGE] = 1'b1; // R12
        end
        if (chg)
        begin
            st_nxt.ctrl[`CTMC_CHDIR] = 1'b1; // R13
        end
        // Interrupt events; flag events need the flag interrupt enable.
        ev = '0;
        ev[`CTMC_IS_OVF] = step & wrap & ~wr_count;
        ev[`CTMC_IS_EDGE] = edge_evt & st_r.ctrl[`CTMC_IREN]; // R15
        ev[`CTMC_IS_CHDIR] = chg & st_r.ctrl[`CTMC_IREN]; // R15
        if (wr_clr)
        begin
            st_nxt.istat = st_r.istat & ~pwdata[2:0];
        end
        st_nxt.istat = st_nxt.istat | ev;
        if (wr_ien)
        begin
            st_nxt.ien = pwdata[2:0];
        end
        st_nxt.irq = |(st_nxt.istat & st_nxt.ien);
        st_nxt.tout = st_nxt.ctrl[`CTMC_OE] & st_nxt.ctrl[`CTMC_OTL]; // R10
        // Read data is captured in the setup phase.
        if (setup_rd)
        begin
            st_nxt.rdata = '0;
            unique case (paddr[11:0])
                `CTMC_OFS_CTRL:
                begin
                    st_nxt.rdata[15:0] = st_r.ctrl; // R1 R14
                end
                `CTMC_OFS_COUNT:
                begin
                    st_nxt.rdata[15:0] = st_r.count;
                end
                `CTMC_OFS_ISTAT:
                begin
                    st_nxt.rdata[2:0] = st_r.istat;
                end
                `CTMC_OFS_IEN:
                begin
                    st_nxt.rdata[2:0] = st_r.ien;
                end
                default:
                begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    // State register with asynchronous reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.ctrl <= `CTMC_CTRL_RST; // R1
            st_r.istat <= `CTMC_INT_RST;
            st_r.ien <= `CTMC_INT_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

endmodule

// File: testbench/ctmc_monitor.sv
`timescale 1ns/1ps
module ctmc_monitor
#(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic toggle_output_pin,
    input wire logic irq
);
    // Access phase and register write qualifiers.
    logic acc;
    logic wr;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Bus answers and refusals.
    a_ready_high: assert property (pready)
        else $error("ready low");
    a_err_access: assert property (pslverr |-> acc)
        else $error("stray error");
    a_err_unmapped: assert property (acc && paddr == 12'h014 |-> pslverr)
        else $error("unmapped taken");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper half set");
    a_refused_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused data");
    // Output pin, interrupt mask and direction readback.
    a_pin_off: assert property (wr && paddr == 12'h000 && pstrb[1] && !pwdata[9] |-> ##2 !toggle_output_pin)
        else $error("pin not off");
    a_irq_masked: assert property (wr && paddr == 12'h010 && pstrb[0] && pwdata[2:0] == 3'h0 |-> ##2 !irq)
        else $error("irq not masked");
    a_dir_shown: assert property (acc && !pwrite && paddr == 12'h000 && !prdata[8] && !prdata[5]
        |-> prdata[14] == prdata[7])
        else $error("direction wrong");
    // Main scenarios reached.
    c_refused: cover property (acc && pslverr);
    c_irq: cover property ($rose(irq));
    c_toggle: cover property ($rose(toggle_output_pin));
endmodule

// File: testbench/ctmc_pins.sv
`timescale 1ns/1ps
module ctmc_pins (
    input wire logic pclk,
    output logic count_input_pin,
    output logic ext_direction_input
);
    // Both lines rest low until a scenario moves them.
    initial
    begin
        count_input_pin = 1'b0;
        ext_direction_input = 1'b0;
    end
    // Sets both lines to fixed levels.
    task automatic lvl(input logic a, input logic b);
        count_input_pin <= a;
        ext_direction_input <= b;
        @(posedge pclk);
    endtask
    // Toggles the count line n times, gap clocks apart.
    task automatic pulses(input int n, input int gap);
        repeat (n)
        begin
            repeat (gap) @(posedge pclk);
            count_input_pin <= ~count_input_pin;
        end
    endtask
    // Steps a two phase encoder n quarter turns; forward when fwd is set.
    task automatic quad(input int n, input int gap, input logic fwd);
        repeat (n)
        begin
            repeat (gap) @(posedge pclk);
            if ((count_input_pin == ext_direction_input) == fwd)
                count_input_pin <= ~count_input_pin;
            else
                ext_direction_input <= ~ext_direction_input;
        end
    endtask
endmodule

// File: testbench/ctmc_top_tb.sv
`timescale 1ns/1ps
module ctmc_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic count_input_pin, ext_direction_input, toggle_output_pin, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0] pstrb;
    logic [15:0] dl;
    int n_errors = 0;
    int n_compared = 0;
    ctmc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_input_pin(count_input_pin), .ext_direction_input(ext_direction_input),
        .toggle_output_pin(toggle_output_pin), .irq(irq));
    ctmc_pins pins (.pclk(pclk), .count_input_pin(count_input_pin), .ext_direction_input(ext_direction_input));
    // Free running clock.
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Compares and counts.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, entered at a clock edge; keeps read data and error.
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // Count change between two reads; kind 1 pulses, 2 and 3 encoder steps.
    task automatic delta(input int w, input int k, input int n);
        logic [15:0] c0;
        apb(1'b0, 12'h004, 16'h0000);
        c0 = rdv[15:0];
        if (k == 1)
            pins.pulses(n, 6);
        if (k > 1)
            pins.quad(n, 8, k == 2);
        repeat (w) @(posedge pclk);
        apb(1'b0, 12'h004, 16'h0000);
        dl = rdv[15:0] - c0;
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h000, 16'h0000);
        check(rdv, 32'h00000000);
        apb(1'b1, 12'h000, 16'hcf12);
        apb(1'b0, 12'h000, 16'h0000);
        check(rdv, 32'h00008f12);
        check(toggle_output_pin, 1'b1);
        apb(1'b1, 12'h000, 16'h0000);
        check(toggle_output_pin, 1'b0);
        apb(1'b0, 12'h014, 16'h0000);
        check(err, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_timer();
        int dv;
        for (int f = 0; f < 2; f++)
            for (int s = 0; s < 8; s++)
            begin
                dv = 1 << (3 + s - f);
                apb(1'b1, 12'h000, 16'(32'h40 | (f << 11) | s));
                delta(2 * dv - 5, 0, 0);
                check(dl, 16'h0002);
            end
        apb(1'b1, 12'h000, 16'h0080);
        delta(11, 0, 0);
        check(dl, 16'h0000);
        apb(1'b1, 12'h000, 16'h00c0);
        delta(11, 0, 0);
        check(dl, 16'hfffe);
        apb(1'b0, 12'h000, 16'h0000);
        check(rdv[14], 1'b1);
        pins.lvl(1'b0, 1'b1);
        apb(1'b1, 12'h000, 16'h0140);
        delta(11, 0, 0);
        check(dl, 16'hfffe);
        $display("test timer done");
    endtask
    task automatic t_count();
        logic [15:0] ex [4] = '{16'h0000, 16'h0002, 16'h0002, 16'h0004};
        pins.lvl(1'b0, 1'b0);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, 12'h000, 16'(32'h48 | s));
            delta(8, 1, 4);
            check(dl, ex[s]);
        end
        apb(1'b0, 12'h000, 16'h0000);
        check(rdv[12], 1'b1);
        pins.lvl(1'b1, 1'b0);
        apb(1'b1, 12'h000, 16'h0050);
        delta(11, 0, 0);
        check(dl, 16'h0000);
        apb(1'b1, 12'h000, 16'h0058);
        delta(11, 0, 0);
        check(dl, 16'h0002);
        $display("test count done");
    endtask
    task automatic t_quad();
        pins.lvl(1'b0, 1'b0);
        apb(1'b1, 12'h010, 16'h0006);
        apb(1'b1, 12'h000, 16'h807b);
        delta(8, 2, 4);
        check(dl, 16'h0004);
        check(irq, 1'b1);
        apb(1'b1, 12'h00c, 16'h0007);
        check(irq, 1'b0);
        delta(8, 3, 4);
        check(dl, 16'hfffc);
        apb(1'b0, 12'h000, 16'h0000);
        check(rdv[14:12], 3'h7);
        apb(1'b1, 12'h010, 16'h0000);
        check(irq, 1'b0);
        // Rotation detection on one phase at a time counts but reports no edges.
        for (int s = 1; s < 3; s++)
        begin
            apb(1'b1, 12'h000, 16'(32'h70 | s));
            delta(8, 2, 4);
            check(dl, 16'h0002);
            apb(1'b0, 12'h000, 16'h0000);
            check(rdv[14:12], (s == 1) ? 3'h2 : 3'h0);
        end
        $display("test quad done");
    endtask
    task automatic t_ovf();
        apb(1'b1, 12'h000, 16'h0000);
        apb(1'b1, 12'h004, 16'hffff);
        apb(1'b1, 12'h00c, 16'h0007);
        apb(1'b1, 12'h010, 16'h0001);
        apb(1'b1, 12'h000, 16'h0a40);
        repeat (12) @(posedge pclk);
        check(toggle_output_pin, 1'b1);
        check(irq, 1'b1);
        apb(1'b1, 12'h008, 16'h0000);
        apb(1'b0, 12'h008, 16'h0000);
        check(rdv[0], 1'b1);
        $display("test overflow done");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Cuts a hang short.
    initial
    begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        results();
    end
    // Reset, then the scenarios in turn.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h3;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_timer();
        t_count();
        t_quad();
        t_ovf();
        results();
    end
endmodule
bind ctmc_top ctmc_monitor #(.ADDR_W(ADDR_W)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .toggle_output_pin(toggle_output_pin), .irq(irq));
